// ==== core/slicer_cmd_pkg.sv ====
// constants, tables and carrier types for the slicer command registers
// Behaviour
// R1 - a byte with bit 7 set names the command; bit 7 clear carries its data
// R2 - codes F5 to F9 pick output control 1, 2, vps mask, pdc masks a and b
// R3 - alternate-count bit set selects the bracketed absent-to-present sampling counts
// R4 - noise field codes 0 to 7 give threshold none, 4 ... 256 pulses per line
// R5 - two-bit clock field picks the sync sampling period for pal or ntsc
// R6 - bits 6 to 4 of output control 1 choose composite sync pin source
// R7 - bits 3 and 2 choose judgement pin: judgement, lock or raw sync detect
// R8 - bit 1 picks falling or rising vertical capture, only with internal separation
// R9 - bit 0 picks vertical separation time about 8.9 or 17.8 us
// R10 - output control 2 bit 5 selects pal or ntsc, bit 4 625 or 525 lines
// R11 - bits 3 and 2 make vertical and horizontal pins sync outputs or ports
// R12 - bits 1 and 0 set pin polarity, or the port level in port mode
// R13 - vps mask bits 5 to 0 switch biphase check of bytes 15..11 and 5
// R14 - with check disable set the mask bits choose retain or write errored data
// R15 - pdc mask a bits 0 to 6 switch hamming check of bytes 13 to 19
// R16 - in header and status modes the same bits switch odd parity checks
// R17 - pdc mask b bits 0 to 5 cover bytes 20 to 25, also parity bytes
// R18 - every command register clears to zero on the reset pin
// R19 - check disable set writes every byte; clear writes only error-free checked bytes (code ignores check disable; writes errored byte if mask bit set)
// R20 - counts 0, 4, 8, 16 become 32, 64, 128, 256 with the alternate bit
// R21 - host sends first byte and data byte in one addressed write transfer
// R22 - a data byte without a recognised first byte changes nothing
package slicer_cmd_pkg;
  // ==========================================================
  // bus and command codes
  localparam logic [7:0] BUS_WRITE_ADDR = 8'h7C;
  localparam int CMD_ID_BIT = 7;
  localparam logic [7:0] CODE_SYNC_TWO = 8'hF4;
  localparam logic [7:0] CODE_OUT_ONE = 8'hF5;
  localparam logic [7:0] CODE_OUT_TWO = 8'hF6;
  localparam logic [7:0] CODE_VPS_MASK = 8'hF7;
  localparam logic [7:0] CODE_PDC_A = 8'hF8;
  localparam logic [7:0] CODE_PDC_B = 8'hF9;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ==========================================================
  // field positions
  localparam int ALT_COUNT_BIT = 5;
  localparam int NOISE_LSB = 2;
  localparam int JCLK_LSB = 0;
  localparam int CSO_LSB = 4;
  localparam int JDG_LSB = 2;
  localparam int EDGE_BIT = 1;
  localparam int VERT_SEP_BIT = 0;
  localparam int STD_BIT = 5;
  localparam int LINES_BIT = 4;
  localparam int VGPIO_BIT = 3;
  localparam int HGPIO_BIT = 2;
  localparam int VPOL_BIT = 1;
  localparam int HPOL_BIT = 0;
  localparam int VPS_BITS = 6;
  localparam int PDC_A_BITS = 7;
  localparam int PDC_B_BITS = 6;
  localparam int MASK_SLOTS = VPS_BITS + PDC_A_BITS + PDC_B_BITS;
  // ==========================================================
  // tables
  localparam logic [8:0] NOISE_TBL [8] = '{9'h000, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
  localparam logic [8:0] COUNT_NORM [4] = '{9'h000, 9'h004, 9'h008, 9'h010};
  localparam logic [8:0] COUNT_ALT [4] = '{9'h020, 9'h040, 9'h080, 9'h100};
  localparam logic [10:0] JCLK_PAL_NS [3] = '{11'h2A5, 11'h387, 11'h1C2};
  localparam logic [10:0] JCLK_NTSC_NS [3] = '{11'h1C0, 11'h346, 11'h45D};
  // ==========================================================
  // timing
  localparam int CLK_NS = 20;
  localparam int VERT_SEP_SHORT_NS = 8900;
  localparam int VERT_SEP_LONG_NS = 17800;
  localparam int VERT_SEP_SHORT_CYC = VERT_SEP_SHORT_NS / CLK_NS;
  localparam int VERT_SEP_LONG_CYC = VERT_SEP_LONG_NS / CLK_NS;
  // ==========================================================
  // types
  typedef struct packed {
    logic [7:0] sync_detect_config_two;
    logic [7:0] output_control_one;
    logic [7:0] output_control_two;
    logic [7:0] vps_check_mask;
    logic [7:0] pdc_check_mask_a;
    logic [7:0] pdc_check_mask_b;
  } cfg_s;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_s;
endpackage

// ==== core/bus_byte_slave.sv ====
// serial bus write-only slave that delivers received bytes
`timescale 1ns/10ps
`default_nettype none
module bus_byte_slave #(
  parameter logic [7:0] DEV_ADDR = slicer_cmd_pkg::BUS_WRITE_ADDR
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic frame_start,
  output slicer_cmd_pkg::rx_byte_s rx
);
  typedef enum logic [3:0] {
    SL_IDLE = 4'b0001,
    SL_RECV = 4'b0010,
    SL_ACK = 4'b0100,
    SL_SKIP = 4'b1000
  } slave_state_e;

  slave_state_e state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic addr_phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  assign start_seen = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop_seen = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign scl_rise = scl_in & ~scl_q_r;
  assign scl_fall = ~scl_in & scl_q_r;
  assign sda_out = 1'b0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end

  // ==========================================================
  // framing and acknowledge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SL_IDLE;
      addr_phase_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sda_oe <= 1'b0;
      frame_start <= 1'b0;
      rx <= '0;
    end else begin
      frame_start <= 1'b0;
      rx.valid <= 1'b0;
      if (start_seen) begin
        state_r <= SL_RECV;
        addr_phase_r <= 1'b1;
        bit_cnt_r <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state_r <= SL_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state_r)
          SL_RECV: begin
            if (scl_rise && bit_cnt_r != 4'h8) begin
              shift_r <= {shift_r[6:0], sda_in};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              // reads and foreign addresses are left unanswered
              if (addr_phase_r && shift_r != DEV_ADDR) begin
                state_r <= SL_SKIP;
              end else begin
                state_r <= SL_ACK;
                sda_oe <= 1'b1;
                frame_start <= addr_phase_r;
                rx.valid <= ~addr_phase_r;
                rx.data <= shift_r;
              end
            end
          end
          SL_ACK: begin
            if (scl_fall) begin
              state_r <= SL_RECV;
              sda_oe <= 1'b0;
              addr_phase_r <= 1'b0;
              bit_cnt_r <= 4'h0;
            end
          end
          SL_IDLE, SL_SKIP: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state_r <= SL_IDLE;
          end
        endcase
      end
    end
  end
endmodule // bus_byte_slave
`default_nettype wire

// ==== core/vbi_slicer_command_regs.sv ====
// command decoder, control registers and the pin logic they steer
`timescale 1ns/10ps
`default_nettype none
module vbi_slicer_command_regs #(
  parameter int CLK_PERIOD_NS = slicer_cmd_pkg::CLK_NS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic error_check_disable,
  input wire logic [1:0] present_code,
  input wire logic composite_sync,
  input wire logic slice_amp,
  input wire logic odd_even,
  input wire logic acq_clk,
  input wire logic [3:0] vco_div,
  input wire logic sync_judge,
  input wire logic lock,
  input wire logic raw_sync_detect,
  input wire logic vsync_int,
  input wire logic hsync_int,
  input wire logic internal_vert_sep,
  input wire logic vert_sep_in,
  input wire logic chk_valid,
  input wire logic chk_err,
  input wire logic [4:0] chk_slot,
  output slicer_cmd_pkg::cfg_s cfg_r,
  output logic [8:0] present_count_r,
  output logic [8:0] noise_threshold_r,
  output logic [10:0] judge_period_ns_r,
  output logic composite_sync_out_pin_r,
  output logic sync_judgement_pin_r,
  output logic vertical_output_pin_r,
  output logic horiz_output_pin_r,
  output logic vert_capture_r,
  output logic vert_sep_window_r,
  output logic store_we_r,
  output logic [18:0] chk_on_r
);
  typedef enum logic [1:0] {
    CMD_WAIT = 2'b01,
    CMD_ARMED = 2'b10
  } cmd_state_e;

  localparam int SEP_SHORT = slicer_cmd_pkg::VERT_SEP_SHORT_NS / CLK_PERIOD_NS;
  localparam int SEP_LONG = slicer_cmd_pkg::VERT_SEP_LONG_NS / CLK_PERIOD_NS;

  // the separation counter is 11 bits wide
  if (CLK_PERIOD_NS < 10 || SEP_SHORT < 1) begin : g_bad_clock
    $error("clock period outside the range the separation counter serves");
  end

  logic frame_start;
  slicer_cmd_pkg::rx_byte_s rx;
  cmd_state_e cmd_state_r;
  logic [2:0] target_r;
  logic [2:0] code_idx;
  logic code_ok;
  logic vert_sep_q_r;
  logic [10:0] vert_sep_cnt_r;
  logic edge_hit;
  logic [slicer_cmd_pkg::MASK_SLOTS-1:0] mask_all;
  logic [7:0] oc1;
  logic [7:0] oc2;
  logic ntsc;

  bus_byte_slave #(
    .DEV_ADDR(slicer_cmd_pkg::BUS_WRITE_ADDR)
  ) u_slave (
    .clock(clock),
    .arst_n(arst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .frame_start(frame_start),
    .rx(rx)
  );

  // ==========================================================
  // command decode
  // R2 first byte codes
  always_comb begin
    code_ok = 1'b1;
    case (rx.data)
      slicer_cmd_pkg::CODE_SYNC_TWO: code_idx = 3'd0;
      slicer_cmd_pkg::CODE_OUT_ONE: code_idx = 3'd1;
      slicer_cmd_pkg::CODE_OUT_TWO: code_idx = 3'd2;
      slicer_cmd_pkg::CODE_VPS_MASK: code_idx = 3'd3;
      slicer_cmd_pkg::CODE_PDC_A: code_idx = 3'd4;
      slicer_cmd_pkg::CODE_PDC_B: code_idx = 3'd5;
      default: begin
        code_idx = 3'd0;
        code_ok = 1'b0;
      end
    endcase
  end

  // R1 first byte arms, data byte completes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_state_r <= CMD_WAIT;
      target_r <= 3'd0;
    end else if (frame_start) begin
      // R21 a command never spans two transfers
      cmd_state_r <= CMD_WAIT;
    end else if (rx.valid) begin
      if (rx.data[slicer_cmd_pkg::CMD_ID_BIT]) begin
        // unknown codes drop the pending command
        cmd_state_r <= code_ok ? CMD_ARMED : CMD_WAIT;
        target_r <= code_idx;
      end else begin
        cmd_state_r <= CMD_WAIT;
      end
    end
  end

  // R18 cleared on reset; R22 stray data ignored
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= {6{slicer_cmd_pkg::REG_RESET}};
    end else if (rx.valid && !rx.data[slicer_cmd_pkg::CMD_ID_BIT] && cmd_state_r == CMD_ARMED && !frame_start) begin
      case (target_r)
        3'd0: cfg_r.sync_detect_config_two <= rx.data;
        3'd1: cfg_r.output_control_one <= rx.data;
        3'd2: cfg_r.output_control_two <= rx.data;
        3'd3: cfg_r.vps_check_mask <= rx.data;
        3'd4: cfg_r.pdc_check_mask_a <= rx.data;
        3'd5: cfg_r.pdc_check_mask_b <= rx.data;
        default: cfg_r.pdc_check_mask_b <= cfg_r.pdc_check_mask_b;
      endcase
    end
  end

  // ==========================================================
  // sync discrimination settings
  assign oc1 = cfg_r.output_control_one;
  assign oc2 = cfg_r.output_control_two;
  // R10 standard select
  assign ntsc = oc2[slicer_cmd_pkg::STD_BIT];

  // R3 alternate counts; R20 scaled table
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      present_count_r <= 9'h000;
    end else if (cfg_r.sync_detect_config_two[slicer_cmd_pkg::ALT_COUNT_BIT]) begin
      present_count_r <= slicer_cmd_pkg::COUNT_ALT[present_code];
    end else begin
      present_count_r <= slicer_cmd_pkg::COUNT_NORM[present_code];
    end
  end

  // R4 noise threshold, zero means none
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      noise_threshold_r <= 9'h000;
    end else begin
      noise_threshold_r <= slicer_cmd_pkg::NOISE_TBL[cfg_r.sync_detect_config_two[slicer_cmd_pkg::NOISE_LSB +: 3]];
    end
  end

  // R5 sampling clock period; code 11 is undefined and reads as 00
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      judge_period_ns_r <= 11'h000;
    end else begin
      case (cfg_r.sync_detect_config_two[slicer_cmd_pkg::JCLK_LSB +: 2])
        2'b01: judge_period_ns_r <= ntsc ? slicer_cmd_pkg::JCLK_NTSC_NS[1] : slicer_cmd_pkg::JCLK_PAL_NS[1];
        2'b10: judge_period_ns_r <= ntsc ? slicer_cmd_pkg::JCLK_NTSC_NS[2] : slicer_cmd_pkg::JCLK_PAL_NS[2];
        default: judge_period_ns_r <= ntsc ? slicer_cmd_pkg::JCLK_NTSC_NS[0] : slicer_cmd_pkg::JCLK_PAL_NS[0];
      endcase
    end
  end

  // ==========================================================
  // pin multiplexers
  // R6 composite sync pin source
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      composite_sync_out_pin_r <= 1'b0;
    end else begin
      case (oc1[slicer_cmd_pkg::CSO_LSB +: 3])
        3'b000: composite_sync_out_pin_r <= composite_sync;
        3'b001: composite_sync_out_pin_r <= slice_amp;
        3'b010: composite_sync_out_pin_r <= odd_even;
        3'b011: composite_sync_out_pin_r <= acq_clk;
        3'b100: composite_sync_out_pin_r <= vco_div[0];
        3'b101: composite_sync_out_pin_r <= vco_div[1];
        3'b110: composite_sync_out_pin_r <= vco_div[2];
        default: composite_sync_out_pin_r <= vco_div[3];
      endcase
    end
  end

  // R7 judgement pin source; code 11 falls back to judgement
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_judgement_pin_r <= 1'b0;
    end else begin
      case (oc1[slicer_cmd_pkg::JDG_LSB +: 2])
        2'b01: sync_judgement_pin_r <= lock;
        2'b10: sync_judgement_pin_r <= raw_sync_detect;
        default: sync_judgement_pin_r <= sync_judge;
      endcase
    end
  end

  // R11 sync or port mode; R12 polarity or port level
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vertical_output_pin_r <= 1'b0;
      horiz_output_pin_r <= 1'b0;
    end else begin
      vertical_output_pin_r <= oc2[slicer_cmd_pkg::VGPIO_BIT] ? oc2[slicer_cmd_pkg::VPOL_BIT] :
                               ~(vsync_int ^ oc2[slicer_cmd_pkg::VPOL_BIT]);
      horiz_output_pin_r <= oc2[slicer_cmd_pkg::HGPIO_BIT] ? oc2[slicer_cmd_pkg::HPOL_BIT] :
                            ~(hsync_int ^ oc2[slicer_cmd_pkg::HPOL_BIT]);
    end
  end

  // ==========================================================
  // vertical capture and separation window
  // R8 edge choice, honoured only with internal separation
  assign edge_hit = internal_vert_sep &&
                    (oc1[slicer_cmd_pkg::EDGE_BIT] ? (vert_sep_in & ~vert_sep_q_r) : (~vert_sep_in & vert_sep_q_r));

  // reset low: the default falling-edge choice cannot fire falsely
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vert_sep_q_r <= 1'b0;
      vert_capture_r <= 1'b0;
    end else begin
      vert_sep_q_r <= vert_sep_in;
      vert_capture_r <= edge_hit;
    end
  end

  // R9 separation time; a new edge restarts the window
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vert_sep_cnt_r <= 11'h000;
      vert_sep_window_r <= 1'b0;
    end else if (edge_hit) begin
      vert_sep_cnt_r <= oc1[slicer_cmd_pkg::VERT_SEP_BIT] ? 11'(SEP_LONG) : 11'(SEP_SHORT);
      vert_sep_window_r <= 1'b1;
    end else if (vert_sep_cnt_r != 11'h000) begin
      vert_sep_cnt_r <= vert_sep_cnt_r - 11'h001;
      vert_sep_window_r <= (vert_sep_cnt_r != 11'h001);
    end else begin
      vert_sep_window_r <= 1'b0;
    end
  end

  // ==========================================================
  // per-byte error checks
  // R13 vps, R15 pdc a, R17 pdc b; R16 parity shares these bits
  assign mask_all = {cfg_r.pdc_check_mask_b[slicer_cmd_pkg::PDC_B_BITS-1:0],
                     cfg_r.pdc_check_mask_a[slicer_cmd_pkg::PDC_A_BITS-1:0],
                     cfg_r.vps_check_mask[slicer_cmd_pkg::VPS_BITS-1:0]};

  // R14 mask meaning follows check disable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      chk_on_r <= '0;
    end else begin
      chk_on_r <= error_check_disable ? '0 : ~mask_all;
    end
  end

  // R19 store write decision; slots past the table never write on error
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      store_we_r <= 1'b0;
    end else begin
      store_we_r <= chk_valid && (!chk_err ||
                    (chk_slot < 5'(slicer_cmd_pkg::MASK_SLOTS) && mask_all[chk_slot]));
    end
  end

  // ==========================================================
  // checks
  logic data_write;
  assign data_write = rx.valid && !rx.data[slicer_cmd_pkg::CMD_ID_BIT] && cmd_state_r == CMD_ARMED && !frame_start;

  // R2 output control 1 write lands
  oc1_write_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
    data_write && target_r == 3'd1 |=> cfg_r.output_control_one == $past(rx.data))
    else $error("output control 1 not updated");

  // R22 stray data byte
  stray_data_a: assert property (@(posedge clock) disable iff (!arst_n) // R22
    rx.valid && !rx.data[slicer_cmd_pkg::CMD_ID_BIT] && cmd_state_r == CMD_WAIT |=> $stable(cfg_r))
    else $error("stray data byte changed a register");

  // R1 command byte never writes
  cmd_byte_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
    rx.valid && rx.data[slicer_cmd_pkg::CMD_ID_BIT] |=> $stable(cfg_r))
    else $error("first byte altered a register");

  // R18 reset value
  reset_clear_a: assert property (@(posedge clock) // R18
    !arst_n |-> cfg_r == '0)
    else $error("registers not cleared under reset");

  // R20 alternate count table
  alt_count_a: assert property (@(posedge clock) disable iff (!arst_n) // R20
    cfg_r.sync_detect_config_two[5] && present_code == 2'b11 ##1 $stable(present_code) && $stable(cfg_r)
    |-> present_count_r == 9'h100)
    else $error("alternate count wrong");

  // R4 noise threshold
  noise_thr_a: assert property (@(posedge clock) disable iff (!arst_n) // R4
    cfg_r.sync_detect_config_two[4:2] == 3'b111 ##1 $stable(cfg_r) |-> noise_threshold_r == 9'h100)
    else $error("noise threshold wrong");

  // R12 port mode level
  vport_level_a: assert property (@(posedge clock) disable iff (!arst_n) // R12
    oc2[3] ##1 $stable(oc2) |-> vertical_output_pin_r == oc2[1])
    else $error("vertical port level wrong");

  // R9 short window length
  sep_window_a: assert property (@(posedge clock) disable iff (!arst_n) // R9
    edge_hit && !oc1[slicer_cmd_pkg::VERT_SEP_BIT] ##1 !edge_hit [*8] |-> vert_sep_window_r)
    else $error("separation window ended early");

  // R8 no capture without internal separation
  edge_gate_a: assert property (@(posedge clock) disable iff (!arst_n) // R8
    !internal_vert_sep |=> !vert_capture_r)
    else $error("capture without internal separation");

  // R19 clean byte always written
  clean_write_a: assert property (@(posedge clock) disable iff (!arst_n) // R19
    chk_valid && !chk_err |=> store_we_r)
    else $error("clean byte not written");

  pdc_b_cmd_c: cover property (@(posedge clock) disable iff (!arst_n)
    data_write && target_r == 3'd5);
  gpio_mode_c: cover property (@(posedge clock) disable iff (!arst_n)
    oc2[3] && oc2[2]);
  err_write_c: cover property (@(posedge clock) disable iff (!arst_n)
    chk_valid && chk_err && error_check_disable ##1 store_we_r);
endmodule // vbi_slicer_command_regs
`default_nettype wire

// ==== tb/host_model.sv ====
// host-side serial bus master model for command writes
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv,
  output logic acked
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    acked = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bit_out(input logic b, output logic s);
    sda_drv = b;
    hold(4);
    scl = 1'b1;
    hold(2);
    s = sda_line;
    hold(2);
    scl = 1'b0;
    hold(1);
  endtask
  task automatic send(input logic [7:0] b[$]);
    logic s;
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(1);
    foreach (b[k]) begin
      for (int i = 7; i >= 0; i--) bit_out(b[k][i], s);
      bit_out(1'b1, s);
      if (k == 0) acked = !s;
    end
    sda_drv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_drv = 1'b1;
    hold(4);
  endtask
endmodule // host_model
`default_nettype wire

// ==== tb/tb_vbi_slicer_command_regs.sv ====
// self-checking bench for the slicer command registers
`timescale 1ns/10ps
`default_nettype none
module tb_vbi_slicer_command_regs;
  logic clock, arst_n, scl, sda_drv, sda_line, sda_out, sda_oe, acked, v_q;
  logic error_check_disable, internal_vert_sep, vert_sep_in, chk_valid, chk_err;
  logic [1:0] present_code;
  logic [4:0] chk_slot;
  logic [12:0] src;
  logic [18:0] m;
  logic [31:0] lfsr = 32'h00013853;
  logic [7:0] er [6];
  logic q [$];
  int errors, tests_run, cycles, n;
  slicer_cmd_pkg::cfg_s cfg_r;
  logic [8:0] present_count_r, noise_threshold_r;
  logic [10:0] judge_period_ns_r;
  logic cso_pin, jdg_pin, v_pin, h_pin, vert_capture_r, vert_sep_window_r, store_we_r;
  logic [18:0] chk_on_r;
  logic [10:0] pal [4] = '{11'h2A5, 11'h387, 11'h1C2, 11'h2A5};
  logic [10:0] ntsc [4] = '{11'h1C0, 11'h346, 11'h45D, 11'h1C0};
  // open-drain data line with pull-up
  assign sda_line = sda_drv & ~(sda_oe & ~sda_out);
  always #10 clock = ~clock;
  host_model u_host (.clock, .sda_line, .scl, .sda_drv, .acked);
  vbi_slicer_command_regs u_dut (
    .clock, .arst_n, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .error_check_disable,
    .present_code, .composite_sync(src[0]), .slice_amp(src[1]), .odd_even(src[2]), .acq_clk(src[3]),
    .vco_div(src[7:4]), .sync_judge(src[8]), .lock(src[9]), .raw_sync_detect(src[10]),
    .vsync_int(src[11]), .hsync_int(src[12]), .internal_vert_sep, .vert_sep_in, .chk_valid, .chk_err,
    .chk_slot, .cfg_r, .present_count_r, .noise_threshold_r, .judge_period_ns_r,
    .composite_sync_out_pin_r(cso_pin), .sync_judgement_pin_r(jdg_pin), .vertical_output_pin_r(v_pin),
    .horiz_output_pin_r(h_pin), .vert_capture_r, .vert_sep_window_r, .store_we_r, .chk_on_r
  );
  // ========
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [47:0] ecfg();
    return {er[0], er[1], er[2], er[3], er[4], er[5]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmd(input int k, input logic [7:0] d);
    u_host.send('{8'h7C, slicer_cmd_pkg::CODE_SYNC_TWO + 8'(k), d});
    er[k] = d;
    tick(4);
  endtask
  // ========
  // monitors
  always @(posedge clock) begin
    v_q <= chk_valid;
    cycles++;
    if (cycles == 60000) begin
      errors++;
      test_done();
    end
  end
  always @(negedge clock) begin
    if (v_q === 1'b1)
      chk(store_we_r, q.pop_front());
  end
  // ========
  // main sequence
  initial begin
    {clock, arst_n, error_check_disable, internal_vert_sep, vert_sep_in, chk_valid, chk_err} = 7'h00;
    {present_code, chk_slot, src} = 20'h00000;
    er = '{default: 8'h00};
    tick(16);
    arst_n = 1'b1;
    chk(cfg_r, 48'h0);
    tick(2);
    for (int k = 0; k < 6; k++) begin
      cmd(k, 8'(rnd()) & 8'h7F);
      chk(cfg_r, ecfg());
      chk(acked, 1'b1);
    end
    u_host.send('{8'h7C, 8'h15, 8'hFB, 8'h22, 8'hF6, 8'h12, 8'h34});
    er[2] = 8'h12;
    tick(4);
    chk(cfg_r, ecfg());
    // a new transfer drops a pending first byte
    u_host.send('{8'h7C, 8'hF5});
    u_host.send('{8'h7C, 8'h55});
    tick(4);
    chk(cfg_r, ecfg());
    u_host.send('{8'h7A, 8'hF5, 8'h33});
    tick(4);
    chk(cfg_r, ecfg());
    chk(acked, 1'b0);
    arst_n = 1'b0;
    tick(2);
    er = '{default: 8'h00};
    chk(cfg_r, 48'h0);
    arst_n = 1'b1;
    tick(3);
    for (int i = 0; i < 16; i++) begin
      present_code = i[1:0];
      cmd(2, {2'b00, i[3], 5'h00});
      cmd(0, {2'b00, i[2], i[2:0], i[1:0]});
      chk(noise_threshold_r, i[2:0] == 0 ? 9'h000 : 9'h001 << (i[2:0] + 1));
      chk(judge_period_ns_r, i[3] ? ntsc[i[1:0]] : pal[i[1:0]]);
      chk(present_count_r, i[2] ? 9'h020 << i[1:0] : (i[1:0] == 0 ? 9'h000 : 9'h002 << i[1:0]));
    end
    for (int c = 0; c < 8; c++) begin
      cmd(1, {1'b0, c[2:0], c[1:0], 2'b00});
      repeat (3) begin
        src = 13'(rnd());
        tick(2);
        chk(cso_pin, src[c]);
        chk(jdg_pin, src[c[1:0] == 3 ? 8 : 8 + c[1:0]]);
      end
    end
    for (int j = 0; j < 16; j++) begin
      cmd(2, {4'h0, j[3:0]});
      src = 13'(rnd());
      tick(2);
      chk(v_pin, j[3] ? j[1] : !(src[11] ^ j[1]));
      chk(h_pin, j[2] ? j[0] : !(src[12] ^ j[0]));
    end
    cmd(3, 8'(rnd()) & 8'h3F);
    cmd(4, 8'(rnd()) & 8'h7F);
    cmd(5, 8'(rnd()) & 8'h3F);
    m = {er[5][5:0], er[4][6:0], er[3][5:0]};
    for (int e = 0; e < 2; e++) begin
      error_check_disable = e[0];
      tick(2);
      chk(chk_on_r, e ? 19'h0 : 19'(~m));
      repeat (20) begin
        chk_slot = 5'(rnd() % 19);
        chk_err = lfsr[7];
        chk_valid = 1'b1;
        q.push_back(!chk_err || m[chk_slot]);
        tick(1);
      end
      chk_valid = 1'b0;
      tick(3);
    end
    internal_vert_sep = 1'b1;
    for (int e = 0; e < 2; e++) begin
      cmd(1, {6'h00, e[0], e[0]});
      vert_sep_in = !e[0];
      tick(4);
      chk(vert_capture_r, 1'b0);
      vert_sep_in = e[0];
      for (n = 0; n < 4 && vert_capture_r !== 1'b1; n++) tick(1);
      chk(vert_capture_r, 1'b1);
      for (n = 0; n < 2000 && vert_sep_window_r === 1'b1; n++) tick(1);
      chk(n, e ? slicer_cmd_pkg::VERT_SEP_LONG_CYC : slicer_cmd_pkg::VERT_SEP_SHORT_CYC);
    end
    test_done();
  end
endmodule // tb_vbi_slicer_command_regs
`default_nettype wire
